/* File: design/rrsse_exec.sv */
/*
 * Decode and execute for return, rotates, sleep and both subtracts.
 * Assumes an external fetch unit presents one instruction per cycle
 * with a valid strobe, an external register file answers reads
 * combinationally, and an external stack supplies its top value.
 */
`timescale 1ns/10ps
module rrsse_exec (
   input  wire logic        core_clk_in,            // Instruction clock
   input  wire logic        rstn_in,                // Async reset, active low
   input  wire logic        insn_valid_in,          // Instruction present
   input  wire logic [13:0] insn_in,                // Instruction word
   input  wire logic [7:0]  file_rdata_in,          // Addressed file register
   input  wire logic [12:0] stack_top_value_in,     // Stack top
   input  wire logic        carry_in,               // Current carry flag
   input  wire logic        wake_in,                // Wake request, leaves sleep
   output logic             insn_ready_out,         // Ready for next instruction
   output logic [6:0]       file_addr_out,          // File address, registered
   output logic             file_we_out,            // File write pulse
   output logic [7:0]       file_wdata_out,         // File write data
   output logic [7:0]       work_out,               // Working register
   output logic             stack_pop_out,          // Stack pop pulse
   output logic             pc_load_out,            // PC load pulse
   output logic [12:0]      pc_value_out,           // PC load value
   output logic             carry_we_out,           // Carry update pulse
   output logic             carry_out,              // New carry
   output logic             nibble_carry_we_out,    // Digit carry update pulse
   output logic             nibble_carry_flag_out,  // New digit carry
   output logic             zero_we_out,            // Zero update pulse
   output logic             zero_out,               // New zero flag
   output logic             osc_stop_out,           // Oscillator stopped
   output logic             sleep_out,              // In sleep state
   output logic             watchdog_clr_out,       // Watchdog and prescaler clear
   output logic [7:0]       watchdog_count_out,     // Value loaded into watchdog
   output logic             timeout_status_n_out,   // Time-out status, low active
   output logic             powerdown_status_n_out  // Power-down status, low active
);
   rrsse_pkg::rrsse_state_t state_q;                // Executor state
   rrsse_pkg::rrsse_state_t state_d;                // Next state
   logic       is_ret;                              // Return decoded
   logic       is_sleep;                            // Sleep decoded
   logic       is_rrf;                              // Right rotate decoded
   logic       is_rlf;                              // Left rotate decoded
   logic       is_file_minus_work_op;                            // File subtract decoded
   logic       is_literal_minus_work_op;                            // Literal subtract decoded
   logic       go;                                  // Instruction accepted
   logic       dest_file;                           // Destination bit
   logic [1:0] op_sel;                              // Unit operation
   logic [7:0] alu_a;                               // Unit first operand
   logic [7:0] alu_res;                             // Unit result
   logic       alu_c;                               // Unit carry
   logic       alu_dc;                              // Unit digit carry
   logic       alu_z;                               // Unit zero
   logic       sleep_q;                             // Sleep state

   // Decode of the six instructions
   always_comb begin
      is_ret    = (insn_in == rrsse_pkg::OPC_RETURN);
      is_sleep  = (insn_in == rrsse_pkg::OPC_SLEEP);
      is_rrf    = (insn_in[13:8] == rrsse_pkg::OPC_RRF_HI);
      is_rlf    = (insn_in[13:8] == rrsse_pkg::OPC_RLF_HI);
      is_file_minus_work_op  = (insn_in[13:8] == rrsse_pkg::OPC_FILE_MINUS_WORK_OP_HI);
      is_literal_minus_work_op  = (insn_in[13:9] == rrsse_pkg::OPC_LITERAL_MINUS_WORK_OP_HI);
      dest_file = insn_in[rrsse_pkg::DEST_POS];
      go        = insn_valid_in & (state_q == rrsse_pkg::RRSSE_RUN) & ~sleep_q;
   end

   // Operand routing into the arithmetic unit
   always_comb begin
      op_sel = 2'h2;
      alu_a  = file_rdata_in;
      if (is_rrf) begin
         op_sel = 2'h0;
      end else if (is_rlf) begin
         op_sel = 2'h1;
      end else if (is_literal_minus_work_op) begin
         alu_a = insn_in[7:0];
      end
   end

   rrsse_alu u_alu (
      .op_sel_in  (op_sel),
      .a_in       (alu_a),
      .w_in       (work_out),
      .carry_in   (carry_in),
      .result_out (alu_res),
      .carry_out  (alu_c),
      .nibble_out (alu_dc),
      .zero_out   (alu_z)
   );

   // Next state: return holds one extra cycle
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         rrsse_pkg::RRSSE_RUN: begin
            if (go && is_ret) begin
               state_d = rrsse_pkg::RRSSE_FLUSH;
            end
         end
         rrsse_pkg::RRSSE_FLUSH: begin
            state_d = rrsse_pkg::RRSSE_RUN;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= rrsse_pkg::RRSSE_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Ready: low during the second return cycle and in sleep
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         insn_ready_out <= 1'b1;
      end else begin
         insn_ready_out <= (state_d == rrsse_pkg::RRSSE_RUN)
                           & ~(go & is_sleep) & ~(sleep_q & ~wake_in);
      end
   end

   // Stack pop and program counter load on return
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stack_pop_out <= 1'b0;
         pc_load_out   <= 1'b0;
         pc_value_out  <= rrsse_pkg::PC_RST;
      end else begin
         stack_pop_out <= go & is_ret;
         pc_load_out   <= go & is_ret;
         if (go && is_ret) begin
            pc_value_out <= stack_top_value_in;
         end
      end
   end

   // Working register updates
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         work_out <= rrsse_pkg::WORK_RST;
      end else if (go && is_literal_minus_work_op) begin
         work_out <= alu_res;
      end else if (go && (is_rrf || is_rlf || is_file_minus_work_op) && !dest_file) begin
         work_out <= alu_res;
      end
   end

   // File register write back
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         file_we_out    <= 1'b0;
         file_addr_out  <= 7'h00;
         file_wdata_out <= 8'h00;
      end else begin
         file_we_out <= go & (is_rrf | is_rlf | is_file_minus_work_op) & dest_file;
         if (go) begin
            file_addr_out  <= insn_in[6:0];
            file_wdata_out <= alu_res;
         end
      end
   end

   // Flag updates; return and sleep leave arithmetic flags alone
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         carry_we_out          <= 1'b0;
         carry_out             <= 1'b0;
         nibble_carry_we_out   <= 1'b0;
         nibble_carry_flag_out <= 1'b0;
         zero_we_out           <= 1'b0;
         zero_out              <= 1'b0;
      end else begin
         carry_we_out        <= go & (is_rrf | is_rlf | is_file_minus_work_op | is_literal_minus_work_op);
         nibble_carry_we_out <= go & (is_file_minus_work_op | is_literal_minus_work_op);
         zero_we_out         <= go & (is_file_minus_work_op | is_literal_minus_work_op);
         carry_out             <= alu_c;
         nibble_carry_flag_out <= alu_dc;
         zero_out              <= alu_z;
      end
   end

   // Sleep state and oscillator stop
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sleep_q      <= 1'b0;
         sleep_out    <= 1'b0;
         osc_stop_out <= 1'b0;
      end else if (go && is_sleep) begin
         sleep_q      <= 1'b1;
         sleep_out    <= 1'b1;
         osc_stop_out <= 1'b1;
      end else if (sleep_q && wake_in) begin
         sleep_q      <= 1'b0;
         sleep_out    <= 1'b0;
         osc_stop_out <= 1'b0;
      end
   end

   // Watchdog clear and status bits on sleep entry
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         watchdog_clr_out       <= 1'b0;
         watchdog_count_out     <= rrsse_pkg::WDT_CLR;
         timeout_status_n_out   <= 1'b1;
         powerdown_status_n_out <= 1'b1;
      end else begin
         watchdog_clr_out <= go & is_sleep;
         if (go && is_sleep) begin
            watchdog_count_out     <= rrsse_pkg::WDT_CLR;
            timeout_status_n_out   <= 1'b1;
            powerdown_status_n_out <= 1'b0;
         end
      end
   end

endmodule : rrsse_exec

/* File: design/rrsse_pkg.sv */
/*
 * Package for the return/rotate/sleep/subtract execute block.
 * Holds opcode patterns, field positions, reset values and cycle counts.
 * Assumes 14-bit instruction words and an 8-bit data path.
 */
package rrsse_pkg;
   // Instruction word layout
   localparam int          INSN_W        = 14;       // Instruction width
   localparam int          DATA_W        = 8;        // Data width
   localparam int          FADDR_W       = 7;        // File address width
   localparam int          PC_W          = 13;       // Program counter width
   localparam int          DEST_POS      = 7;        // Destination bit position
   // Fixed opcodes
   localparam logic [13:0] OPC_RETURN    = 14'h0008; // Subroutine return
   localparam logic [13:0] OPC_SLEEP     = 14'h0063; // Sleep entry
   // Major opcode fields, bits 13:8 (literal subtract uses bits 13:9)
   localparam logic [5:0]  OPC_RRF_HI    = 6'h0c;    // Rotate right through carry
   localparam logic [5:0]  OPC_RLF_HI    = 6'h0d;    // Rotate left through carry
   localparam logic [5:0]  OPC_FILE_MINUS_WORK_OP_HI  = 6'h02;    // File minus work
   localparam logic [4:0]  OPC_LITERAL_MINUS_WORK_OP_HI  = 5'h1e;    // Literal minus work, bits 13:9
   // Reset values
   localparam logic [7:0]  WORK_RST      = 8'h00;    // Working register
   localparam logic [7:0]  WDT_CLR       = 8'h00;    // Watchdog cleared value
   localparam logic [12:0] PC_RST        = 13'h0000; // Program counter
   // Return takes two cycles: one extra stall cycle
   localparam logic [1:0]  RET_CYCLES    = 2'h2;     // Cycles for return
   // Executor states
   typedef enum logic [0:0] {
      RRSSE_RUN   = 1'b0,                           // Normal execution
      RRSSE_FLUSH = 1'b1                            // Second return cycle
   } rrsse_state_t;
endpackage : rrsse_pkg

/* File: design/rrsse_alu.sv */
/*
 * Arithmetic unit: rotates and subtraction with flag results.
 * Purely combinational; fed by the executor on the same clock.
 */
`timescale 1ns/10ps
module rrsse_alu (
   input  wire logic [1:0] op_sel_in,     // 0 rrf, 1 rlf, 2 subtract
   input  wire logic [7:0] a_in,          // Minuend or rotate source
   input  wire logic [7:0] w_in,          // Working register
   input  wire logic       carry_in,      // Old carry
   output logic      [7:0] result_out,    // Result
   output logic            carry_out,     // New carry
   output logic            nibble_out,    // New digit carry
   output logic            zero_out       // Result is zero
);
   logic [8:0] diff;                       // Full difference with borrow
   logic [4:0] ndiff;                      // Low nibble difference

   // Operation select
   always_comb begin
      diff       = {1'b0, a_in} - {1'b0, w_in};
      ndiff      = {1'b0, a_in[3:0]} - {1'b0, w_in[3:0]};
      result_out = diff[7:0];
      carry_out  = ~diff[8];
      nibble_out = ~ndiff[4];
      unique case (op_sel_in)
         2'h0: begin                       // Right rotate
            result_out = {carry_in, a_in[7:1]};
            carry_out  = a_in[0];
         end
         2'h1: begin                       // Left rotate
            result_out = {a_in[6:0], carry_in};
            carry_out  = a_in[7];
         end
         default: begin                    // Subtract, computed above
         end
      endcase
      zero_out = (result_out == 8'h00);
   end
endmodule : rrsse_alu

/* File: test/rrsse_exec_chk.sv */
/* Checker: timing properties on the ports of rrsse_exec.
   Assumes one clock and an async active-low reset; bound below. */
`timescale 1ns/10ps
module rrsse_exec_chk (
   input wire logic        core_clk_in,
   input wire logic        rstn_in,
   input wire logic        insn_valid_in,
   input wire logic [13:0] insn_in,
   input wire logic [7:0]  file_rdata_in,
   input wire logic [12:0] stack_top_value_in,
   input wire logic        carry_in,
   input wire logic        insn_ready_out,
   input wire logic [6:0]  file_addr_out,
   input wire logic        file_we_out,
   input wire logic [7:0]  file_wdata_out,
   input wire logic [7:0]  work_out,
   input wire logic        stack_pop_out,
   input wire logic        pc_load_out,
   input wire logic [12:0] pc_value_out,
   input wire logic        carry_we_out,
   input wire logic        carry_out,
   input wire logic        nibble_carry_flag_out,
   input wire logic        zero_we_out,
   input wire logic        zero_out,
   input wire logic        osc_stop_out,
   input wire logic        sleep_out,
   input wire logic        watchdog_clr_out,
   input wire logic [7:0]  watchdog_count_out,
   input wire logic        timeout_status_n_out,
   input wire logic        powerdown_status_n_out
);
   wire       tk  = insn_valid_in && insn_ready_out;              // Request taken
   wire       ret = insn_in == rrsse_pkg::OPC_RETURN;             // Return
   wire       slp = insn_in == rrsse_pkg::OPC_SLEEP;              // Sleep
   wire       sl  = insn_in[13:9] == rrsse_pkg::OPC_LITERAL_MINUS_WORK_OP_HI;     // Literal subtract
   wire       rr  = insn_in[13:8] == rrsse_pkg::OPC_RRF_HI;       // Right rotate
   wire       rl  = insn_in[13:8] == rrsse_pkg::OPC_RLF_HI;       // Left rotate
   wire       alu = rr || rl || insn_in[13:8] == rrsse_pkg::OPC_FILE_MINUS_WORK_OP_HI; // Has dest bit
   wire [6:0] fa  = insn_in[6:0];                                 // File address
   wire [7:0] a   = sl ? insn_in[7:0] : file_rdata_in;            // Minuend
   wire [7:0] res = rr ? {carry_in, file_rdata_in[7:1]} :
                    rl ? {file_rdata_in[6:0], carry_in} : a - work_out; // Expected result
   wire       rc  = rr ? file_rdata_in[0] : file_rdata_in[7];     // Rotate carry out
   wire       cx  = a >= work_out;                                // No borrow
   wire       dx  = a[3:0] >= work_out[3:0];                      // No nibble borrow
   wire       zx  = res == 8'h00;                                 // Zero result
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   ret_pop_a: assert property (tk && ret |=> stack_pop_out && pc_load_out
      && !zero_we_out && pc_value_out == $past(stack_top_value_in)) else $error("bad return");
   ret_gap_a: assert property (tk && ret |=> !insn_ready_out ##1 insn_ready_out)
      else $error("return gap");
   rrf_carry_a: assert property (tk && rr |=> carry_we_out && carry_out == $past(rc))
      else $error("right rotate carry");
   rlf_carry_a: assert property (tk && rl |=> carry_we_out && carry_out == $past(rc))
      else $error("left rotate carry");
   dest_file_a: assert property (tk && alu && insn_in[7] |=> file_we_out
      && file_wdata_out == $past(res) && file_addr_out == $past(fa)) else $error("file dest");
   dest_work_a: assert property (tk && (alu && !insn_in[7] || sl) |=> !file_we_out
      && work_out == $past(res)) else $error("work dest");
   sleep_go_a: assert property (tk && slp |=> sleep_out && osc_stop_out && !insn_ready_out)
      else $error("sleep entry");
   sleep_clr_a: assert property (tk && slp |=> watchdog_clr_out && !carry_we_out
      && watchdog_count_out == 8'h00 && !powerdown_status_n_out && timeout_status_n_out)
      else $error("sleep side effects");
   sub_flags_a: assert property (tk && (sl || alu && !rr && !rl) |=> carry_out == $past(cx)
      && nibble_carry_flag_out == $past(dx) && zero_out == $past(zx)) else $error("sub flags");
endmodule : rrsse_exec_chk

bind rrsse_exec rrsse_exec_chk i_rrsse_exec_chk (.*);

/* File: test/rrsse_exec_test.sv */
/* Bench: random instruction stream checked against an integer model.
   Assumes the checker binds itself to rrsse_exec. */
`timescale 1ns/10ps
module rrsse_exec_test;
   logic core_clk_in = 1'b0, rstn_in = 1'b0, insn_valid_in = 1'b0; // Clock, reset, valid
   logic carry_in = 1'b0, wake_in = 1'b0;                 // Flag in, wake
   logic [13:0] insn_in = 14'h0000;                       // Instruction
   logic [7:0] file_rdata_in = 8'h00;                     // File read data
   logic [12:0] stack_top_value_in = 13'h0000;            // Stack top
   logic insn_ready_out, file_we_out, stack_pop_out, pc_load_out, carry_we_out, carry_out;
   logic nibble_carry_we_out, nibble_carry_flag_out, zero_we_out, zero_out, osc_stop_out;
   logic sleep_out, watchdog_clr_out, timeout_status_n_out, powerdown_status_n_out;
   logic [6:0] file_addr_out;                             // File address
   logic [7:0] file_wdata_out, work_out, watchdog_count_out; // Data outputs
   logic [12:0] pc_value_out;                             // PC load value
   logic [31:0] lf = 32'h8604;                            // Random state
   int error_cnt = 0, n_checks = 0, w = 0;                // Counters, model W
   int ek = 0, er, ec, edc, ez, epc, ea, erdy = 1;        // Pending result
   bit asleep = 1'b0;                                     // Model sleep
   localparam logic [6:0] PV [7] = '{7'h00, 7'h06, 7'h20, 7'h60, 7'h38, 7'h78, 7'h01};
   wire [6:0] pulses = {file_we_out, carry_we_out, nibble_carry_we_out, zero_we_out,
                        stack_pop_out, pc_load_out, watchdog_clr_out}; // Pulse group
   wire [11:0] slp_v = {sleep_out, osc_stop_out, watchdog_count_out,
                        powerdown_status_n_out, timeout_status_n_out}; // Sleep group
   rrsse_exec i_rrsse_exec (.core_clk_in, .rstn_in, .insn_valid_in, .insn_in, .file_rdata_in,
      .stack_top_value_in, .carry_in, .wake_in, .insn_ready_out, .file_addr_out, .file_we_out,
      .file_wdata_out, .work_out, .stack_pop_out, .pc_load_out, .pc_value_out, .carry_we_out,
      .carry_out, .nibble_carry_we_out, .nibble_carry_flag_out, .zero_we_out, .zero_out,
      .osc_stop_out, .sleep_out, .watchdog_clr_out, .watchdog_count_out,
      .timeout_status_n_out, .powerdown_status_n_out);
   // 25 MHz clock
   always #20 core_clk_in = ~core_clk_in;
   // Random step
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   // Compare one value
   task automatic chk(input string nm, input logic [12:0] got, input int ex);
      n_checks++;
      if (got !== 13'(ex)) begin
         error_cnt++;
         $display("[FAIL] %s expected %0h got %0h", nm, ex, got);
      end
   endtask : chk
   // Verdict and end of run
   task automatic test_done();
      if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   // Results of the previous request
   task automatic cmp();
      chk("pulses", pulses, PV[ek]);
      chk("ready", insn_ready_out, erdy);
      chk("work", work_out, w);
      if (ek == 1) chk("pc", pc_value_out, epc);
      if (ek == 3 || ek == 5) chk("wdata", file_wdata_out, er);
      if (ek == 3 || ek == 5) chk("addr", file_addr_out, ea);
      if (ek > 1 && ek < 6) chk("carry", carry_out, ec);
      if (ek == 4 || ek == 5) chk("dc_z", {nibble_carry_flag_out, zero_out}, edc * 2 + ez);
      if (ek == 6) chk("sleep", slp_v, 12'hc01);
   endtask : cmp
   // Drive one request at an edge, then check the one before
   task automatic step(input logic [2:0] k);
      int f, c, m, r, cy, nk;
      logic [13:0] op;
      @(posedge core_clk_in);
      lf = nxt(lf);
      f = lf[7:0];
      c = lf[25];
      case (k)
         3'h0: op = rrsse_pkg::OPC_RETURN;
         3'h1: op = {rrsse_pkg::OPC_RRF_HI, lf[15:8]};
         3'h2: op = {rrsse_pkg::OPC_RLF_HI, lf[15:8]};
         3'h3: op = {rrsse_pkg::OPC_FILE_MINUS_WORK_OP_HI, lf[15:8]};
         3'h4: op = {rrsse_pkg::OPC_LITERAL_MINUS_WORK_OP_HI, lf[24:16]};
         3'h5: op = rrsse_pkg::OPC_SLEEP;
         default: op = {6'h3a, lf[15:8]};                             // Not decoded here
      endcase
      m = (k == 3'h4) ? op[7:0] : f;
      r = (k == 3'h1) ? (c << 7 | f >> 1) : (k == 3'h2) ? ((f << 1) & 255 | c) : (m - w) & 255;
      cy = (k == 3'h1) ? f & 1 : (k == 3'h2) ? f >> 7 : m >= w;
      nk = (ek == 1 || asleep) ? 0 : k == 0 ? 1 : k == 5 ? 6 : k > 5 ? 0 : k < 3 ? 2 : 4;
      if ((nk == 2 || nk == 4) && k != 3'h4 && op[7]) nk++;
      insn_valid_in <= 1'b1;
      insn_in <= op;
      file_rdata_in <= f[7:0];
      carry_in <= c[0];
      stack_top_value_in <= lf[28:16];
      #1 cmp();
      ek = nk;
      er = r;
      ec = cy;
      edc = (m & 15) >= (w & 15);
      ez = r == 0;
      epc = lf[28:16];
      ea = op[6:0];
      if (nk == 2 || nk == 4) w = r;
      erdy = !(nk == 1 || nk == 6) && !asleep;
      if (nk == 6) asleep = 1'b1;
   endtask : step
   // Main sequence
   initial begin
      int i, n;
      repeat (20) @(posedge core_clk_in);
      chk("reset", {work_out, insn_ready_out, timeout_status_n_out, powerdown_status_n_out,
          sleep_out}, 12'h00e);
      rstn_in <= 1'b1;
      for (n = 0; n < 300; n++) begin
         lf = nxt(lf);
         step(lf[31:29]);
         if (asleep) begin
            step(3'h1);                                               // Refused while asleep
            step(3'h4);
            @(posedge core_clk_in);
            insn_valid_in <= 1'b0;
            wake_in <= 1'b1;
            #1 cmp();
            @(posedge core_clk_in);
            wake_in <= 1'b0;
            #1;
            for (i = 0; i < 20 && insn_ready_out !== 1'b1; i++) @(posedge core_clk_in) #1;
            chk("wake", insn_ready_out, 1);
            asleep = 1'b0;
            ek = 0;
            erdy = 1;
         end
      end
      step(3'h7);
      test_done();
   end
   // Hang guard
   initial begin
      #(40 * 5000);
      error_cnt++;
      test_done();
   end
endmodule : rrsse_exec_test
